// >>> fault_severity_output_response.sv
// Purpose: Fault response of a controller CPU: lamps, fail contacts, output hold/reset
// Assumes: Error inputs come from other domains; Avalon-MM register access
// Notes:   Contact outputs high means contact closed
// Functional notes
// R1: Group one items: Stop moderate, Run minor, Stop
// R2: Group two items default Run, minor
// R3: Standard power dip: A open, B closed, hold
// R4: Immediate power dip: A closed, reset ordinary
// R5: Sequence stop resets small RESET modules only
// R6: HOLD setting holds outputs on stop
// R7: Language CPU moderate: fault lamp, hold all
// R8: Language CPU minor: warning lamp, continue
// R9: Debug mode lights warning lamp
// R10: OS-free request or watchdog closes A
// R11: OS-free hold/reset per 8 points, HOLD
// R12: Standard CPU stop/routine/ready-off closes A
// R13: Standard CPU stop mode per 8, HOLD
// R14: Advanced module relays always held on stop
// R15: Normal: A open, B closed; reset closes A
`default_nettype none
`include "fault_resp_regs.svh"
module fault_severity_output_response
  import fault_resp_pkg::*;
#(
  parameter int                 NGRP     = 8,
  parameter int                 NCFG     = 8,
  parameter logic [`FR_WDT_W-1:0] WDT_LOAD = `FR_WDT_LOAD_RST
)(
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire logic [`FR_ADDR_W-1:0] address,
  input  wire logic                  read,
  input  wire logic                  write,
  input  wire logic [31:0]           writedata,
  output logic      [31:0]           readdata,
  output logic                       waitrequest,
  input  wire logic [NCFG-1:0]       cfgErr1,
  input  wire logic [NCFG-1:0]       cfgErr2,
  input  wire logic                  fixedMajor,
  input  wire logic                  fixedModerate,
  input  wire logic                  fixedMinor,
  input  wire logic                  powerFail,
  input  wire logic                  ioErrInterrupt,
  output logic                       failContactA,
  output logic                       failContactB,
  output logic                       readyLamp,
  output logic                       faultLamp,
  output logic                       warningLamp,
  output logic      [NGRP-1:0]       outReset,
  output logic                       irq
);
  localparam int NPIN = 2 * NCFG + 5;

  logic [NPIN-1:0]         pinMeta_q;
  logic [NPIN-1:0]         pinSync_q;
  logic [31:0]             readdata_q;
  logic                    waitrequest_q;
  logic [`FR_CTRL_W-1:0]   ctrl_q;
  logic [NCFG-1:0]         stop1_q;
  logic [NCFG-1:0]         stop2_q;
  logic [NGRP-1:0]         stopMode_q;
  logic [NGRP-1:0]         smallMod_q;
  logic [NGRP-1:0]         denseMod_q;
  logic [`FR_IRQ_W-1:0]    irqStat_q;
  logic [`FR_IRQ_W-1:0]    irqMask_q;
  logic [`FR_IRQ_W-1:0]    evPrev_q;
  logic [`FR_WDT_W-1:0]    wdtLoad_q;
  logic [`FR_WDT_W-1:0]    wdtCnt_q;
  logic                    wdtTimeout_q;
  logic                    failContactA_q;
  logic                    failContactB_q;
  logic                    readyLamp_q;
  logic                    faultLamp_q;
  logic                    warningLamp_q;
  logic [NGRP-1:0]         outReset_q;
  logic                    irq_q;
  logic                    acc;
  logic                    wrEn;
  logic                    rdEn;
  logic                    kick;
  logic                    pfSync;
  logic                    ioIntSync;
  logic [`FR_IRQ_W-1:0]    evNow;
  logic [`FR_IRQ_W-1:0]    evRise;
  logic                    failA;
  logic [NGRP-1:0]         rstGrp;
  logic [31:0]             rdVal;
  cpu_kind_t               cpuKind;
  logic                    pfImm;
  logic                    errStop;
  logic                    readyOff;
  logic                    osfFail;

  sev_if #(.NCFG(NCFG)) sev ();

  function automatic logic hit(input logic [`FR_ADDR_W-1:0] ofs);
    hit = (address == ofs);
  endfunction : hit

  function automatic logic [NGRP-1:0] heldMask(input logic [NGRP-1:0] sel,
                                                 input logic [NGRP-1:0] dense);
    heldMask = sel & ~dense; // R14
  endfunction : heldMask

  // Two-flop synchronisers on all pin inputs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pinMeta_q <= '0;
      pinSync_q <= '0;
    end else begin
      pinMeta_q <= {ioErrInterrupt, powerFail, fixedMinor, fixedModerate, fixedMajor,
                    cfgErr2, cfgErr1};
      pinSync_q <= pinMeta_q;
    end
  end

  assign pfSync    = pinSync_q[2*NCFG+3];
  assign ioIntSync = pinSync_q[2*NCFG+4];
  assign cpuKind   = cpu_kind_t'(ctrl_q[`FR_CTRL_CPU_HI:`FR_CTRL_CPU_LO]);

  assign pfImm    = pfSync & ctrl_q[`FR_CTRL_PFIMM]; // R4
  assign errStop  = sev.major | sev.moderate; // R5 R12
  assign readyOff = ~readyLamp_q; // R12
  assign osfFail  = ctrl_q[`FR_CTRL_FAILREQ] | wdtTimeout_q; // R10

  assign sev.cfgErr1       = pinSync_q[NCFG-1:0];
  assign sev.cfgErr2       = pinSync_q[2*NCFG-1:NCFG];
  assign sev.fixedMajor    = pinSync_q[2*NCFG];
  assign sev.fixedModerate = pinSync_q[2*NCFG+1];
  assign sev.fixedMinor    = pinSync_q[2*NCFG+2] | ioIntSync; // R8
  assign sev.powerFail     = pfSync;
  assign sev.stop1         = stop1_q;
  assign sev.stop2         = stop2_q;

  severity_classifier u_cls (
    .clk  (clk),
    .nrst (nrst),
    .sev  (sev)
  );

  // Avalon-MM slave: one wait cycle, then the access completes
  assign acc  = read | write;
  assign wrEn = write & ~waitrequest_q;
  assign rdEn = read & waitrequest_q;

  always_comb begin
    kick = wrEn & hit(`FR_OFS_WDTKICK);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      waitrequest_q <= 1'b1;
    end else begin
      waitrequest_q <= ~(acc & waitrequest_q);
    end
  end

  always_comb begin
    rdVal = 32'h0000_0000;
    if (hit(`FR_OFS_CTRL)) begin
      rdVal[`FR_CTRL_W-1:0] = ctrl_q;
    end else if (hit(`FR_OFS_ACTION)) begin
      rdVal[2*NCFG-1:0] = {stop2_q, stop1_q};
    end else if (hit(`FR_OFS_STOPMODE)) begin
      rdVal[NGRP-1:0] = stopMode_q;
    end else if (hit(`FR_OFS_SMALLMOD)) begin
      rdVal[NGRP-1:0] = smallMod_q;
    end else if (hit(`FR_OFS_DENSEMOD)) begin
      rdVal[NGRP-1:0] = denseMod_q;
    end else if (hit(`FR_OFS_STATUS)) begin
      rdVal[7:0] = {wdtTimeout_q, sev.minor, sev.moderate, sev.major, warningLamp_q,
                    faultLamp_q, failContactB_q, failContactA_q};
      rdVal[8+NGRP-1:8] = outReset_q;
    end else if (hit(`FR_OFS_IRQSTAT)) begin
      rdVal[`FR_IRQ_W-1:0] = irqStat_q;
    end else if (hit(`FR_OFS_IRQMASK)) begin
      rdVal[`FR_IRQ_W-1:0] = irqMask_q;
    end else if (hit(`FR_OFS_WDTLOAD)) begin
      rdVal[`FR_WDT_W-1:0] = wdtLoad_q;
    end else if (hit(`FR_OFS_WDTKICK)) begin
      rdVal[`FR_WDT_W-1:0] = wdtCnt_q;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      readdata_q <= 32'h0000_0000;
    end else if (rdEn) begin
      readdata_q <= rdVal;
    end
  end

  // Configuration registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q     <= `FR_CTRL_RST;
      stop1_q    <= `FR_ACT1_RST; // R1
      stop2_q    <= `FR_ACT2_RST; // R2
      stopMode_q <= `FR_STOPMODE_RST; // R11 R13
      smallMod_q <= `FR_SMALLMOD_RST;
      denseMod_q <= `FR_DENSEMOD_RST;
      irqMask_q  <= `FR_IRQMASK_RST;
      wdtLoad_q  <= WDT_LOAD;
    end else if (wrEn) begin
      if (hit(`FR_OFS_CTRL)) begin
        ctrl_q <= writedata[`FR_CTRL_W-1:0];
      end else if (hit(`FR_OFS_ACTION)) begin
        stop1_q <= writedata[NCFG-1:0];
        stop2_q <= writedata[2*NCFG-1:NCFG];
      end else if (hit(`FR_OFS_STOPMODE)) begin
        stopMode_q <= writedata[NGRP-1:0];
      end else if (hit(`FR_OFS_SMALLMOD)) begin
        smallMod_q <= writedata[NGRP-1:0];
      end else if (hit(`FR_OFS_DENSEMOD)) begin
        denseMod_q <= writedata[NGRP-1:0];
      end else if (hit(`FR_OFS_IRQMASK)) begin
        irqMask_q <= writedata[`FR_IRQ_W-1:0];
      end else if (hit(`FR_OFS_WDTLOAD)) begin
        wdtLoad_q <= writedata[`FR_WDT_W-1:0];
      end
    end
  end

  // Watchdog for the OS-free CPU
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wdtCnt_q     <= WDT_LOAD;
      wdtTimeout_q <= 1'b0;
    end else if (!ctrl_q[`FR_CTRL_WDTEN] || kick) begin
      wdtCnt_q     <= wdtLoad_q;
      wdtTimeout_q <= 1'b0;
    end else if (wdtCnt_q == '0) begin
      wdtTimeout_q <= 1'b1; // R10
    end else begin
      wdtCnt_q <= wdtCnt_q - 1'b1;
    end
  end

  // Fail contact and output group decisions
  always_comb begin
    failA  = 1'b0;
    rstGrp = '0;
    case (cpuKind)
      CPU_SEQ: begin
        failA = errStop;
        if (failA) begin
          rstGrp = heldMask(stopMode_q & smallMod_q, denseMod_q); // R5 R6 R14
        end
      end
      CPU_PROG: begin
        failA = sev.major; // R7 R8
        if (sev.major) begin
          rstGrp = heldMask(stopMode_q, denseMod_q); // R6 R14
        end
      end
      CPU_OSFREE: begin
        failA = osfFail; // R10
        if (failA) begin
          rstGrp = heldMask(stopMode_q, denseMod_q); // R10 R11 R14
        end
      end
      default: begin
        failA = errStop | ctrl_q[`FR_CTRL_ROUTINE] | readyOff; // R12
        if (failA) begin
          rstGrp = heldMask(stopMode_q, denseMod_q); // R13 R14
        end
      end
    endcase
    if (pfImm) begin
      failA  = 1'b1; // R4
      rstGrp = rstGrp | heldMask({NGRP{1'b1}}, denseMod_q); // R4
    end
  end

  // Contacts: reset stands for the unpowered state
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      failContactA_q <= 1'b1; // R15
      failContactB_q <= 1'b0; // R15
    end else begin
      failContactA_q <= failA; // R3 R15
      failContactB_q <= ~failA; // R3 R15
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      outReset_q <= '0;
    end else begin
      outReset_q <= rstGrp; // R3
    end
  end

  // Lamps
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      readyLamp_q   <= 1'b0;
      faultLamp_q   <= 1'b0;
      warningLamp_q <= 1'b0;
    end else begin
      readyLamp_q   <= ~sev.major;
      faultLamp_q   <= sev.moderate; // R7
      warningLamp_q <= sev.minor | ctrl_q[`FR_CTRL_DEBUG]; // R8 R9
    end
  end

  // Sticky event flags, write one to clear, set wins
  assign evNow = {pfSync, wdtTimeout_q, sev.minor, sev.moderate, sev.major};
  assign evRise = evNow & ~evPrev_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      evPrev_q  <= '0;
      irqStat_q <= '0;
    end else begin
      evPrev_q <= evNow;
      if (wrEn && hit(`FR_OFS_IRQSTAT)) begin
        irqStat_q <= (irqStat_q & ~writedata[`FR_IRQ_W-1:0]) | evRise;
      end else begin
        irqStat_q <= irqStat_q | evRise;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irqStat_q & irqMask_q);
    end
  end

  assign readdata     = readdata_q;
  assign waitrequest  = waitrequest_q;
  assign failContactA = failContactA_q;
  assign failContactB = failContactB_q;
  assign readyLamp    = readyLamp_q;
  assign faultLamp    = faultLamp_q;
  assign warningLamp  = warningLamp_q;
  assign outReset     = outReset_q;
  assign irq          = irq_q;
endmodule : fault_severity_output_response
`default_nettype wire

// >>> fault_resp_regs.svh
// Purpose: Register offsets, fields, reset values and counts of the fault response block
// Assumes: 32-bit Avalon-MM data, byte addresses, word aligned registers
// Notes:   Included by bare name
`ifndef FAULT_RESP_REGS_SVH
`define FAULT_RESP_REGS_SVH

`define FR_ADDR_W         8
`define FR_OFS_CTRL       8'h00
`define FR_OFS_ACTION     8'h04
`define FR_OFS_STOPMODE   8'h08
`define FR_OFS_SMALLMOD   8'h0c
`define FR_OFS_DENSEMOD   8'h10
`define FR_OFS_STATUS     8'h14
`define FR_OFS_IRQSTAT    8'h18
`define FR_OFS_IRQMASK    8'h1c
`define FR_OFS_WDTKICK    8'h20
`define FR_OFS_WDTLOAD    8'h24

`define FR_CTRL_CPU_LO    0
`define FR_CTRL_CPU_HI    1
`define FR_CTRL_PFIMM     2
`define FR_CTRL_DEBUG     3
`define FR_CTRL_FAILREQ   4
`define FR_CTRL_ROUTINE   5
`define FR_CTRL_WDTEN     6
`define FR_CTRL_W         7

`define FR_CTRL_RST       7'h00
`define FR_ACT1_RST       8'hff
`define FR_ACT2_RST       8'h00
`define FR_STOPMODE_RST   8'h00
`define FR_SMALLMOD_RST   8'hff
`define FR_DENSEMOD_RST   8'h00
`define FR_IRQMASK_RST    5'h00

`define FR_IRQ_MAJOR      0
`define FR_IRQ_MODERATE   1
`define FR_IRQ_MINOR      2
`define FR_IRQ_WDT        3
`define FR_IRQ_PWRFAIL    4
`define FR_IRQ_W          5

`define FR_WDT_W          24
`define FR_WDT_LOAD_RST   24'h9c4000

`endif

// >>> fault_resp_pkg.sv
// Purpose: Types of the fault response block
// Assumes: Nothing beyond the register header
// Notes:   CPU kind values are the CTRL cpu field
`default_nettype none
package fault_resp_pkg;
  typedef enum logic [1:0] {
    CPU_SEQ,
    CPU_PROG,
    CPU_OSFREE,
    CPU_STD
  } cpu_kind_t;
endpackage : fault_resp_pkg
`default_nettype wire

// >>> sev_if.sv
// Purpose: Carries error inputs, action settings and severity results
// Assumes: One clock domain
// Notes:   Between the top and the severity classifier
`default_nettype none
interface sev_if #(parameter int NCFG = 8);
  logic [NCFG-1:0] cfgErr1;
  logic [NCFG-1:0] cfgErr2;
  logic [NCFG-1:0] stop1;
  logic [NCFG-1:0] stop2;
  logic            fixedMajor;
  logic            fixedModerate;
  logic            fixedMinor;
  logic            powerFail;
  logic            major;
  logic            moderate;
  logic            minor;
  modport src (output cfgErr1, cfgErr2, stop1, stop2, fixedMajor, fixedModerate,
               fixedMinor, powerFail, input major, moderate, minor);
  modport cls (input cfgErr1, cfgErr2, stop1, stop2, fixedMajor, fixedModerate,
               fixedMinor, powerFail, output major, moderate, minor);
endinterface : sev_if
`default_nettype wire

// >>> severity_classifier.sv
// Purpose: Sorts active error items into major, moderate and minor
// Assumes: Inputs already synchronised to clk
// Notes:   Outputs registered
`default_nettype none
module severity_classifier
  import fault_resp_pkg::*;
(
  input  wire logic clk,
  input  wire logic nrst,
  sev_if.cls        sev
);
  logic majorQ;
  logic moderateQ;
  logic minorQ;
  logic stopHit;
  logic runHit;

  always_comb begin
    stopHit = |(sev.cfgErr1 & sev.stop1) | |(sev.cfgErr2 & sev.stop2); // R1 R2
    runHit  = |(sev.cfgErr1 & ~sev.stop1) | |(sev.cfgErr2 & ~sev.stop2); // R1 R2
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      majorQ    <= 1'b0;
      moderateQ <= 1'b0;
      minorQ    <= 1'b0;
    end else begin
      majorQ    <= sev.fixedMajor;
      moderateQ <= sev.fixedModerate | stopHit; // R1
      minorQ    <= sev.fixedMinor | runHit | sev.powerFail; // R2
    end
  end

  assign sev.major    = majorQ;
  assign sev.moderate = moderateQ;
  assign sev.minor    = minorQ;
endmodule : severity_classifier
`default_nettype wire

// >>> fault_resp_props.sv
// Purpose: Port-level assertions of the fault response block
// Assumes: One clock, nrst asynchronous active low
// Notes:   Bound to the top module after endmodule
`default_nettype none
`include "fault_resp_regs.svh"
module fault_resp_props
  import fault_resp_pkg::*;
#(
  parameter int                   NGRP     = 8,
  parameter int                   NCFG     = 8,
  parameter logic [`FR_WDT_W-1:0] WDT_LOAD = `FR_WDT_LOAD_RST
)(
  input wire logic                  clk,
  input wire logic                  nrst,
  input wire logic [`FR_ADDR_W-1:0] address,
  input wire logic                  read,
  input wire logic                  write,
  input wire logic [31:0]           writedata,
  input wire logic [31:0]           readdata,
  input wire logic                  waitrequest,
  input wire logic [NCFG-1:0]       cfgErr1,
  input wire logic [NCFG-1:0]       cfgErr2,
  input wire logic                  fixedMajor,
  input wire logic                  fixedModerate,
  input wire logic                  fixedMinor,
  input wire logic                  powerFail,
  input wire logic                  ioErrInterrupt,
  input wire logic                  failContactA,
  input wire logic                  failContactB,
  input wire logic                  readyLamp,
  input wire logic                  faultLamp,
  input wire logic                  warningLamp,
  input wire logic [NGRP-1:0]       outReset,
  input wire logic                  irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  contact_pair_a: assert property (
    failContactB != failContactA) else $error("Fail contacts not complementary");
  wait_pulse_a: assert property (
    !waitrequest |=> waitrequest) else $error("Answer longer than one cycle");
  bus_answer_a: assert property (
    (read || write) && waitrequest |=> !waitrequest) else $error("Request not answered");
  rdata_hold_a: assert property (
    $changed(readdata) |-> !waitrequest) else $error("Read data moved outside answer");
  major_ready_a: assert property (
    fixedMajor [*6] |-> !readyLamp) else $error("Ready lamp on in major failure");
  ready_on_a: assert property (
    (!fixedMajor) [*6] |-> readyLamp) else $error("Ready lamp off without major failure");
  moderate_lamp_a: assert property (
    fixedModerate [*6] |-> faultLamp) else $error("Fault lamp off in moderate failure");
  minor_lamp_a: assert property (
    fixedMinor [*6] |-> warningLamp) else $error("Warning lamp off in minor failure");
  reset_closes_a: assert property (
    outReset != '0 |-> failContactA) else $error("Outputs reset with contact A open");
endmodule : fault_resp_props
bind fault_severity_output_response fault_resp_props #(
  .NGRP(NGRP), .NCFG(NCFG), .WDT_LOAD(WDT_LOAD)) fault_resp_props_i (
  .clk(clk), .nrst(nrst), .address(address), .read(read), .write(write),
  .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
  .cfgErr1(cfgErr1), .cfgErr2(cfgErr2), .fixedMajor(fixedMajor),
  .fixedModerate(fixedModerate), .fixedMinor(fixedMinor), .powerFail(powerFail),
  .ioErrInterrupt(ioErrInterrupt), .failContactA(failContactA),
  .failContactB(failContactB), .readyLamp(readyLamp), .faultLamp(faultLamp),
  .warningLamp(warningLamp), .outReset(outReset), .irq(irq));
`default_nettype wire

// >>> field_side_model.sv
// Purpose: Field side: output module image and fail contact loop
// Assumes: Each outReset bit stands for one group of 8 output points
// Notes:   Reset forces a group off, hold keeps the commanded image
`default_nettype none
module field_side_model (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [7:0] outReset,
  input  wire logic [7:0] cmdImage,
  input  wire logic       contactA,
  input  wire logic       contactB,
  output logic      [7:0] fieldOut,
  output logic            loopOk
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fieldOut <= 8'h00;
    end else begin
      fieldOut <= cmdImage & ~outReset;
    end
  end
  assign loopOk = contactA ^ contactB;
endmodule : field_side_model
`default_nettype wire

// >>> tb_top.sv
// Purpose: Self-checking bench of the fault response block
// Assumes: 40 MHz clock, watchdog load shortened to 16
// Notes:   Pin effects checked 6 cycles after a change
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, nrst, read, write, fixedMajor, fixedModerate, fixedMinor;
  logic        powerFail, ioErrInterrupt, waitrequest, failContactA, failContactB;
  logic        readyLamp, faultLamp, warningLamp, irq, loopOk;
  logic [7:0]  address, cfgErr1, cfgErr2, outReset, fieldOut;
  logic [31:0] writedata, readdata, rd;
  int          err_count, checks_done;
  logic [7:0]  ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h1c, 8'h24, 8'h02};
  logic [31:0] rv [8] = '{32'h0, 32'hff, 32'h0, 32'hff, 32'h0, 32'h0, 32'h10, 32'h0};
  fault_severity_output_response #(.NGRP(8), .NCFG(8), .WDT_LOAD(24'h10))
    fault_severity_output_response_i (
    .clk(clk), .nrst(nrst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .cfgErr1(cfgErr1), .cfgErr2(cfgErr2), .fixedMajor(fixedMajor),
    .fixedModerate(fixedModerate), .fixedMinor(fixedMinor), .powerFail(powerFail),
    .ioErrInterrupt(ioErrInterrupt), .failContactA(failContactA),
    .failContactB(failContactB), .readyLamp(readyLamp), .faultLamp(faultLamp),
    .warningLamp(warningLamp), .outReset(outReset), .irq(irq));
  field_side_model field_side_model_i (
    .clk(clk), .nrst(nrst), .outReset(outReset), .cmdImage(8'hff),
    .contactA(failContactA), .contactB(failContactB), .fieldOut(fieldOut),
    .loopOk(loopOk));
  always #12.5 clk = ~clk;
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0);
    chk("bus latency", 32'h2, n);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic outs(input logic a, input logic [7:0] o, input logic f, input logic w);
    repeat (6) @(posedge clk);
    #1;
    chk("contact A", {31'h0, a}, {31'h0, failContactA});
    chk("contact B", {31'h0, !a}, {31'h0, failContactB});
    chk("outReset", {24'h0, o}, {24'h0, outReset});
    chk("fault lamp", {31'h0, f}, {31'h0, faultLamp});
    chk("warning lamp", {31'h0, w}, {31'h0, warningLamp});
    chk("loop", 32'h1, {31'h0, loopOk});
  endtask : outs
  task automatic close_out;
    $display("Checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out
  initial begin
    #150000;
    err_count++;
    close_out();
  end
  initial begin
    {clk, nrst, read, write, fixedMajor, fixedModerate, fixedMinor} = 7'h00;
    {powerFail, ioErrInterrupt, address, cfgErr1, cfgErr2, writedata} = 58'h0;
    repeat (3) @(posedge clk);
    #1;
    chk("unpowered A", 32'h1, {31'h0, failContactA});
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    outs(1'b0, 8'h00, 1'b0, 1'b0);
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, ra[i], 32'h0);
      chk("register", rv[i], rd);
    end
    bus(1'b1, 8'h08, 32'h0f);
    bus(1'b1, 8'h10, 32'h01);
    @(posedge clk) cfgErr1 <= 8'h01;
    outs(1'b1, 8'h0e, 1'b1, 1'b0);
    chk("field image", 32'hf1, {24'h0, fieldOut});
    bus(1'b1, 8'h04, 32'hfe);
    outs(1'b0, 8'h00, 1'b0, 1'b1);
    @(posedge clk) cfgErr1 <= 8'h00;
    @(posedge clk) cfgErr2 <= 8'h08;
    outs(1'b0, 8'h00, 1'b0, 1'b1);
    bus(1'b1, 8'h04, 32'h8fe);
    outs(1'b1, 8'h0e, 1'b1, 1'b0);
    @(posedge clk) cfgErr2 <= 8'h00;
    @(posedge clk) powerFail <= 1'b1;
    outs(1'b0, 8'h00, 1'b0, 1'b1);
    bus(1'b1, 8'h00, 32'h04);
    outs(1'b1, 8'hfe, 1'b0, 1'b1);
    @(posedge clk) powerFail <= 1'b0;
    bus(1'b1, 8'h00, 32'h01);
    @(posedge clk) fixedModerate <= 1'b1;
    outs(1'b0, 8'h00, 1'b1, 1'b0);
    @(posedge clk) fixedModerate <= 1'b0;
    @(posedge clk) ioErrInterrupt <= 1'b1;
    outs(1'b0, 8'h00, 1'b0, 1'b1);
    @(posedge clk) {ioErrInterrupt, fixedMinor} <= 2'b01;
    outs(1'b0, 8'h00, 1'b0, 1'b1);
    @(posedge clk) fixedMinor <= 1'b0;
    bus(1'b1, 8'h00, 32'h09);
    outs(1'b0, 8'h00, 1'b0, 1'b1);
    bus(1'b1, 8'h00, 32'h12);
    outs(1'b1, 8'h0e, 1'b0, 1'b0);
    bus(1'b1, 8'h18, 32'h1f);
    bus(1'b1, 8'h1c, 32'h08);
    bus(1'b1, 8'h00, 32'h42);
    repeat (40) @(posedge clk);
    #1;
    chk("timeout A", 32'h1, {31'h0, failContactA});
    chk("irq on", 32'h1, {31'h0, irq});
    bus(1'b0, 8'h18, 32'h0);
    chk("irq status", 32'h08, rd & 32'h08);
    bus(1'b1, 8'h00, 32'h02);
    bus(1'b1, 8'h20, 32'h0);
    bus(1'b1, 8'h18, 32'h08);
    outs(1'b0, 8'h00, 1'b0, 1'b0);
    chk("irq off", 32'h0, {31'h0, irq});
    bus(1'b1, 8'h00, 32'h23);
    outs(1'b1, 8'h0e, 1'b0, 1'b0);
    bus(1'b1, 8'h00, 32'h03);
    @(posedge clk) fixedMajor <= 1'b1;
    outs(1'b1, 8'h0e, 1'b0, 1'b0);
    chk("ready lamp", 32'h0, {31'h0, readyLamp});
    close_out();
  end
endmodule : tb_top
`default_nettype wire
